// ===== hdl/tcpu_top.sv
// timer, counter and pwm unit with apb register access
`timescale 1ns/1ps
`include "tcpu_consts.svh"
module tcpu_top #(
   parameter int UNIT_ID = 0
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        countIn,
   input  wire logic        captureIn,
   output logic             underflowOut,
   output logic             overflowOut,
   output logic             matchOut,
   output logic             pwmOut,
   output logic             irqOut
);
   // ----------------------------------------------------------------------
   // instance independence
   // ----------------------------------------------------------------------
   // no state is shared, so any number of copies run fully independent; UNIT_ID only names one

   // ----------------------------------------------------------------------
   // input conditioning
   // ----------------------------------------------------------------------
   tcpu_pkg::tcpu_state_t stR;
   tcpu_pkg::tcpu_state_t stNxt;
   logic [1:0]            inEvt;

   tcpu_in_cond u_in (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pinIn    ({captureIn, countIn}),
      .modeSel  (stR.insel),
      .eventOut (inEvt)
   );

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   logic                 enable;
   logic                 useInput;
   logic                 presTick;
   logic                 tick;
   logic                 wrAcc;
   logic                 rdSetup;
   logic                 mapped;
   logic [3:0]           setBits;
   logic [3:0]           clrBits;
   tcpu_pkg::tcpu_dir_t  dir;
   tcpu_pkg::tcpu_func_t func;

   assign enable   = stR.ctrl[`TCPU_CTRL_EN];
   assign useInput = stR.ctrl[`TCPU_CTRL_SRC];
   assign dir      = tcpu_pkg::tcpu_dir_t'(stR.ctrl[`TCPU_CTRL_DIR_LO +: 2]);
   assign func     = tcpu_pkg::tcpu_func_t'(stR.ctrl[`TCPU_CTRL_FUNC_LO +: 2]);
   assign presTick = (stR.div == stR.presc);
   assign tick     = enable & (useInput ? inEvt[0] : presTick);
   assign wrAcc    = psel & penable & stR.pready & pwrite;
   assign rdSetup  = psel & ~penable;

   // address decode
   always_comb begin
      unique case (paddr)
         `TCPU_OFF_CTRL, `TCPU_OFF_INSEL, `TCPU_OFF_PERIOD, `TCPU_OFF_COMPARE,
         `TCPU_OFF_COUNTER, `TCPU_OFF_CAPTURE, `TCPU_OFF_INTSTAT,
         `TCPU_OFF_INTMASK, `TCPU_OFF_PRESCALE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      stNxt = stR;
      setBits = 4'h0;
      clrBits = 4'h0;
      stNxt.unf = 1'b0;
      stNxt.ovf = 1'b0;
      stNxt.match = 1'b0;

      // prescaler gives one-cycle tick enables
      if (!enable || presTick) begin
         stNxt.div = 16'h0000;
      end else begin
         stNxt.div = stR.div + 16'h0001;
      end

      // counter in the selected direction
      if (tick) begin
         unique case (dir)
            tcpu_pkg::TCPU_DIR_UP: begin
               if (stR.cnt >= stR.period) begin
                  stNxt.cnt = 16'h0000;
                  stNxt.ovf = 1'b1;
               end else begin
                  stNxt.cnt = stR.cnt + 16'h0001;
               end
            end
            tcpu_pkg::TCPU_DIR_DOWN: begin
               if (stR.cnt == 16'h0000) begin
                  stNxt.cnt = stR.period;
                  stNxt.unf = 1'b1;
               end else begin
                  stNxt.cnt = stR.cnt - 16'h0001;
               end
            end
            tcpu_pkg::TCPU_DIR_UPDN: begin
               if (!stR.down && stR.cnt >= stR.period) begin
                  stNxt.down = 1'b1;
                  stNxt.ovf = 1'b1;
                  stNxt.cnt = (stR.period == 16'h0000) ? 16'h0000 : stR.cnt - 16'h0001;
               end else if (stR.down && stR.cnt == 16'h0000) begin
                  stNxt.down = 1'b0;
                  stNxt.unf = 1'b1;
                  stNxt.cnt = (stR.period == 16'h0000) ? 16'h0000 : 16'h0001;
               end else if (stR.down) begin
                  stNxt.cnt = stR.cnt - 16'h0001;
               end else begin
                  stNxt.cnt = stR.cnt + 16'h0001;
               end
            end
            default: begin
               stNxt.cnt = stR.cnt;
            end
         endcase
         stNxt.match = (stNxt.cnt == stR.compare);
      end

      // capture on the selected capture event
      if (enable && func == tcpu_pkg::TCPU_FN_CAPT && inEvt[1]) begin
         stNxt.cap = stR.cnt;
         setBits[`TCPU_ST_CAPT] = 1'b1;
      end

      // pwm output high while counter is below compare
      stNxt.pwm = enable && func == tcpu_pkg::TCPU_FN_PWM && (stNxt.cnt < stR.compare);

      setBits[`TCPU_ST_UNDER] = stNxt.unf;
      setBits[`TCPU_ST_OVER]  = stNxt.ovf;
      setBits[`TCPU_ST_MATCH] = stNxt.match;

      // register writes take effect at the access edge
      if (wrAcc) begin
         unique case (paddr)
            `TCPU_OFF_CTRL:     stNxt.ctrl = pwdata[5:0];
            `TCPU_OFF_INSEL:    stNxt.insel = pwdata[3:0];
            `TCPU_OFF_PERIOD:   stNxt.period = pwdata[15:0];
            `TCPU_OFF_COMPARE:  stNxt.compare = pwdata[15:0];
            `TCPU_OFF_COUNTER:  stNxt.cnt = pwdata[15:0];
            `TCPU_OFF_INTSTAT:  clrBits = pwdata[3:0];
            `TCPU_OFF_INTMASK:  stNxt.mask = pwdata[3:0];
            `TCPU_OFF_PRESCALE: stNxt.presc = pwdata[15:0];
            default: ;
         endcase
      end
      if (wrAcc && paddr == `TCPU_OFF_CTRL && !pwdata[`TCPU_CTRL_EN]) begin
         stNxt.down = 1'b0; // restart up/down pattern rising
      end

      // sticky status: a new event wins over a write-one clear
      stNxt.stat = (stR.stat & ~clrBits) | setBits;
      stNxt.irq = |(stNxt.stat & stNxt.mask);

      // read data and answer prepared in the setup cycle
      stNxt.pready = rdSetup;
      stNxt.pslverr = rdSetup & ~mapped;
      stNxt.prdata = 32'h0000_0000;
      if (rdSetup && !pwrite) begin
         unique case (paddr)
            `TCPU_OFF_CTRL:     stNxt.prdata = {26'h0, stR.ctrl};
            `TCPU_OFF_INSEL:    stNxt.prdata = {28'h0, stR.insel};
            `TCPU_OFF_PERIOD:   stNxt.prdata = {16'h0, stR.period};
            `TCPU_OFF_COMPARE:  stNxt.prdata = {16'h0, stR.compare};
            `TCPU_OFF_COUNTER:  stNxt.prdata = {16'h0, stR.cnt};
            `TCPU_OFF_CAPTURE:  stNxt.prdata = {16'h0, stR.cap};
            `TCPU_OFF_INTSTAT:  stNxt.prdata = {28'h0, stR.stat};
            `TCPU_OFF_INTMASK:  stNxt.prdata = {28'h0, stR.mask};
            `TCPU_OFF_PRESCALE: stNxt.prdata = {16'h0, stR.presc};
            default:            stNxt.prdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stR         <= '0;
         stR.ctrl    <= `TCPU_RST_CTRL;
         stR.insel   <= `TCPU_RST_INSEL;
         stR.period  <= `TCPU_RST_PERIOD;
         stR.compare <= `TCPU_RST_COMPARE;
         stR.presc   <= `TCPU_RST_PRESCALE;
      end else begin
         stR <= stNxt;
      end
   end

   // outputs straight from the state register
   assign prdata       = stR.prdata;
   assign pready       = stR.pready;
   assign pslverr      = stR.pslverr;
   assign underflowOut = stR.unf;
   assign overflowOut  = stR.ovf;
   assign matchOut     = stR.match;
   assign pwmOut       = stR.pwm;
   assign irqOut       = stR.irq;
endmodule // tcpu_top

// ===== hdl/tcpu_consts.svh
// register offsets, field positions, reset values and sizes of the timer unit
`ifndef TCPU_CONSTS_SVH
`define TCPU_CONSTS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TCPU_OFF_CTRL     8'h00
`define TCPU_OFF_INSEL    8'h04
`define TCPU_OFF_PERIOD   8'h08
`define TCPU_OFF_COMPARE  8'h0c
`define TCPU_OFF_COUNTER  8'h10
`define TCPU_OFF_CAPTURE  8'h14
`define TCPU_OFF_INTSTAT  8'h18
`define TCPU_OFF_INTMASK  8'h1c
`define TCPU_OFF_PRESCALE 8'h20
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TCPU_CTRL_EN      0
`define TCPU_CTRL_DIR_LO  1
`define TCPU_CTRL_FUNC_LO 3
`define TCPU_CTRL_SRC     5
`define TCPU_INSEL_CNT_LO 0
`define TCPU_INSEL_CAP_LO 2
`define TCPU_ST_UNDER     0
`define TCPU_ST_OVER      1
`define TCPU_ST_MATCH     2
`define TCPU_ST_CAPT      3
// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define TCPU_RST_CTRL     6'h00
`define TCPU_RST_INSEL    4'h0
`define TCPU_RST_PERIOD   16'hffff
`define TCPU_RST_COMPARE  16'h0000
`define TCPU_RST_PRESCALE 16'h0000
`define TCPU_MAX_UNITS    4
`define TCPU_NUM_IN       2
`endif

// ===== hdl/tcpu_pkg.sv
// types shared by the timer unit files
package tcpu_pkg;
   typedef enum logic [1:0] {
      TCPU_DIR_UP   = 2'b00,
      TCPU_DIR_DOWN = 2'b01,
      TCPU_DIR_UPDN = 2'b10
   } tcpu_dir_t;

   typedef enum logic [1:0] {
      TCPU_FN_TIMER = 2'b00,
      TCPU_FN_PWM   = 2'b01,
      TCPU_FN_CAPT  = 2'b10
   } tcpu_func_t;

   typedef enum logic [1:0] {
      TCPU_EDGE_RISE = 2'b00,
      TCPU_EDGE_FALL = 2'b01,
      TCPU_EDGE_BOTH = 2'b10,
      TCPU_EDGE_PASS = 2'b11
   } tcpu_edge_t;

   // per-input synchroniser and event state
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      logic evt;
   } tcpu_sync_t;

   // state of the timer unit outside the input synchronisers
   typedef struct packed {
      logic [5:0]  ctrl;
      logic [3:0]  insel;
      logic [15:0] period;
      logic [15:0] compare;
      logic [15:0] cnt;
      logic [15:0] cap;
      logic [3:0]  stat;
      logic [3:0]  mask;
      logic [15:0] presc;
      logic [15:0] div;
      logic        down;
      logic        unf;
      logic        ovf;
      logic        match;
      logic        pwm;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tcpu_state_t;
endpackage

// ===== hdl/tcpu_in_cond.sv
// input conditioning: pin synchronisers and edge or level event selection
`timescale 1ns/1ps
`include "tcpu_consts.svh"
module tcpu_in_cond (
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire logic [`TCPU_NUM_IN-1:0]   pinIn,
   input  wire logic [2*`TCPU_NUM_IN-1:0] modeSel,
   output logic      [`TCPU_NUM_IN-1:0]   eventOut
);
   genvar gi;
   generate
      for (gi = 0; gi < `TCPU_NUM_IN; gi++) begin : g_in
         tcpu_pkg::tcpu_sync_t syncR;
         tcpu_pkg::tcpu_sync_t syncNxt;
         tcpu_pkg::tcpu_edge_t mode;
         logic                 newFilt;

         assign mode = tcpu_pkg::tcpu_edge_t'(modeSel[2*gi +: 2]);

         // three stages; a change counts once stages two and three agree
         always_comb begin
            syncNxt = syncR;
            syncNxt.s1 = pinIn[gi];
            syncNxt.s2 = syncR.s1;
            syncNxt.s3 = syncR.s2;
            newFilt = (syncR.s2 == syncR.s3) ? syncR.s3 : syncR.filt;
            syncNxt.filt = newFilt;
            unique case (mode)
               tcpu_pkg::TCPU_EDGE_RISE: syncNxt.evt = newFilt & ~syncR.filt;
               tcpu_pkg::TCPU_EDGE_FALL: syncNxt.evt = ~newFilt & syncR.filt;
               tcpu_pkg::TCPU_EDGE_BOTH: syncNxt.evt = newFilt ^ syncR.filt;
               tcpu_pkg::TCPU_EDGE_PASS: syncNxt.evt = newFilt;
            endcase
         end

         // register the state
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               syncR <= '0;
            end else begin
               syncR <= syncNxt;
            end
         end

         assign eventOut[gi] = syncR.evt;
      end
   endgenerate
endmodule // tcpu_in_cond

// ===== bench/tcpu_properties.sv
// concurrent checks on the apb answer and the event outputs of the timer unit
`timescale 1ns/1ps
module tcpu_properties (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        underflowOut,
   input wire logic        overflowOut,
   input wire logic        matchOut,
   input wire logic        pwmOut,
   input wire logic        irqOut
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------------
   // bus steps
   // ----------------------------------------------------------------------
   sequence setupS;
      psel && !penable;
   endsequence
   sequence wrS;
      psel && penable && pready && pwrite;
   endsequence
   sequence ctrlOffS;
      wrS and (paddr == 8'h00 && !pwdata[0]);
   endsequence
   sequence maskOffS;
      wrS and (paddr == 8'h1c && pwdata[3:0] == 4'h0);
   endsequence
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   ready_after_setup_a: assert property (setupS |=> pready) else $error("no ready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("ready outside access");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   err_unmapped_a: assert property ((psel && !penable && paddr[1:0] == 2'b00)
      |=> pslverr == ($past(paddr) > 8'h20)) else $error("wrong error answer");
   wrap_mutex_a: assert property (!(underflowOut && overflowOut)) else $error("both wraps");
   mask_off_irq_a: assert property (maskOffS |-> ##2 !irqOut) else $error("masked irq high");
   ctrl_off_quiet_a: assert property (ctrlOffS |-> ##3
      (!underflowOut && !overflowOut && !matchOut && !pwmOut) [*2])
      else $error("events while disabled");
endmodule // tcpu_properties

bind tcpu_top tcpu_properties u_props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .underflowOut(underflowOut),
   .overflowOut(overflowOut), .matchOut(matchOut), .pwmOut(pwmOut), .irqOut(irqOut));

// ===== bench/tcpu_pin_model.sv
// routed pin source: bursts of three pulses on the count or the capture pin
`timescale 1ns/1ps
module tcpu_pin_model (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic fire,
   input  wire logic sel,
   output logic      countIn,
   output logic      captureIn,
   output logic      busy
);
   logic [5:0] step_r;
   logic       sel_r;
   // 48-cycle burst counter, started by fire when idle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_r <= 6'h00;
         sel_r  <= 1'b0;
      end else if (fire && step_r == 6'h00) begin
         step_r <= 6'h30;
         sel_r  <= sel;
      end else if (step_r != 6'h00) begin
         step_r <= step_r - 6'h01;
      end
   end
   // pins high 8 cycles of every 16, low between bursts
   assign busy      = step_r != 6'h00;
   assign countIn   = busy && !sel_r && step_r[3];
   assign captureIn = busy && sel_r && step_r[3];
endmodule // tcpu_pin_model

// ===== bench/timer_counter_pwm_unit_test.sv
// self-checking bench of the timer unit over apb
`timescale 1ns/1ps
`include "tcpu_consts.svh"
module timer_counter_pwm_unit_test;
   logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        fire = 1'b0, sel = 1'b0, pready, pslverr, err, busy, countIn, captureIn;
   logic        underflowOut, overflowOut, matchOut, pwmOut, irqOut;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [31:0] evExp [4] = '{32'h3, 32'h3, 32'h6, 32'h18};
   int          mismatches = 0, cmp_count = 0;
   always #2.5 core_clk = ~core_clk;
   tcpu_top #(.UNIT_ID(3)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .countIn(countIn), .captureIn(captureIn),
      .underflowOut(underflowOut), .overflowOut(overflowOut), .matchOut(matchOut),
      .pwmOut(pwmOut), .irqOut(irqOut));
   tcpu_pin_model u_pins (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .sel(sel),
      .countIn(countIn), .captureIn(captureIn), .busy(busy));
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic end_sim;
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
      chk({31'h0, err}, {31'h0, a > 8'h20});
   endtask
   // counts event pulses and pwm high cycles over 24 settled cycles
   task automatic watch(input int eo, input int eu, input int em, input int ep);
      logic [31:0] o, u, m, p;
      o = 0;
      u = 0;
      m = 0;
      p = 0;
      repeat (6) @(posedge core_clk);
      repeat (24) begin
         @(posedge core_clk);
         o += overflowOut;
         u += underflowOut;
         m += matchOut;
         p += pwmOut;
      end
      chk(o, eo);
      chk(u, eu);
      chk(m, em);
      chk(p, ep);
      apb(1'b1, `TCPU_OFF_CTRL, 32'h0);
   endtask
   task automatic pins(input logic s);
      fire <= 1'b1;
      sel  <= s;
      @(posedge core_clk);
      fire <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 80 && busy !== 1'b0; i++) @(posedge core_clk);
      repeat (10) @(posedge core_clk);
   endtask
   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, then an unmapped word
      for (int a = 0; a <= 36; a += 4) rd(a[7:0], (a == 8) ? 32'hffff : 32'h0);
      apb(1'b1, `TCPU_OFF_INTMASK, 32'hf);
      apb(1'b1, `TCPU_OFF_PERIOD, 32'h2);
      apb(1'b1, `TCPU_OFF_COMPARE, 32'h1);
      // up with pwm, down, up/down
      apb(1'b1, `TCPU_OFF_CTRL, 32'h09);
      watch(8, 0, 8, 8);
      apb(1'b1, `TCPU_OFF_CTRL, 32'h03);
      watch(0, 8, 8, 0);
      apb(1'b1, `TCPU_OFF_CTRL, 32'h05);
      watch(6, 6, 12, 0);
      chk({31'h0, irqOut}, 32'h1);
      rd(`TCPU_OFF_INTSTAT, 32'h7);
      apb(1'b1, `TCPU_OFF_INTSTAT, 32'h7);
      rd(`TCPU_OFF_INTSTAT, 32'h0);
      chk({31'h0, irqOut}, 32'h0);
      // count events from the pin in each edge mode
      apb(1'b1, `TCPU_OFF_PERIOD, 32'hffff);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `TCPU_OFF_INSEL, m);
         apb(1'b1, `TCPU_OFF_COUNTER, 32'h0);
         apb(1'b1, `TCPU_OFF_CTRL, 32'h21);
         pins(1'b0);
         rd(`TCPU_OFF_COUNTER, evExp[m]);
         apb(1'b1, `TCPU_OFF_CTRL, 32'h0);
      end
      // capture of a held count, read-only holding register
      apb(1'b1, `TCPU_OFF_INTSTAT, 32'hf);
      apb(1'b1, `TCPU_OFF_PRESCALE, 32'hffff);
      apb(1'b1, `TCPU_OFF_COUNTER, 32'h1234);
      apb(1'b1, `TCPU_OFF_INSEL, 32'h0);
      apb(1'b1, `TCPU_OFF_CTRL, 32'h11);
      pins(1'b1);
      rd(`TCPU_OFF_CAPTURE, 32'h1234);
      apb(1'b1, `TCPU_OFF_CAPTURE, 32'h0);
      rd(`TCPU_OFF_CAPTURE, 32'h1234);
      rd(`TCPU_OFF_INTSTAT, 32'h8);
      chk({31'h0, irqOut}, 32'h1);
      apb(1'b1, `TCPU_OFF_INTMASK, 32'h0);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqOut}, 32'h0);
      end_sim();
   end
   // watchdog
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
endmodule // timer_counter_pwm_unit_test
